// ### verilog/bome_consts.svh
// Constants of the bit-operation and block-move execution unit.
`ifndef BOME_CONSTS_SVH
`define BOME_CONSTS_SVH
`define BOME_PC_W        24
`define BOME_CCR_W       8
`define BOME_NREG        8
`define BOME_CCR_RST     8'h80
`define BOME_CCR_C       0
`define BOME_CCR_Z       2
`define BOME_PC_RST      24'h000000
`define BOME_SP_IDX      3'h7
`define BOME_CNT_IDX     3'h4
`define BOME_SRC_IDX     3'h5
`define BOME_DST_IDX     3'h6
`define BOME_OP1_HI      15
`define BOME_OP1_LO      12
`define BOME_OP2_HI      11
`define BOME_OP2_LO      8
`define BOME_MOVE_WORD   4'h4
`endif

// ### verilog/bome_pkg.sv
// Types of the bit-operation and block-move execution unit.
`default_nettype none
package bome_pkg;
  typedef enum logic [3:0] {
    BOME_OP_NOP,
    BOME_OP_BIT_SET_OP_X,
    BOME_OP_SET,
    BOME_OP_CLEAR,
    BOME_OP_INVERT,
    BOME_OP_TEST,
    BOME_OP_CAND,
    BOME_OP_CANDN,
    BOME_OP_COR,
    BOME_OP_CORN,
    BOME_OP_MOVE
  } bome_op_e;
  typedef enum logic [2:0] {
    BOME_ST_FETCH,
    BOME_ST_OPREAD,
    BOME_ST_OPWAIT,
    BOME_ST_MVREAD,
    BOME_ST_MVWAIT,
    BOME_ST_MVWRITE,
    BOME_ST_OPWRITE
  } bome_state_e;
endpackage : bome_pkg
`default_nettype wire

// ### verilog/bome_exec.sv
// Bit-operation and block-move execution unit with register file and fetch.
`timescale 1ns/10ps
`default_nettype none
`include "bome_consts.svh"
module bome_exec
  import bome_pkg::*;
#(
  parameter int NREG = `BOME_NREG
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic [15:0]             fetch_word_i,
  input  wire logic                    fetch_valid_i,
  input  wire logic [7:0]              mem_rdata_i,
  input  wire logic                    mem_ack_i,
  output logic                         fetch_req_o,
  output logic [`BOME_PC_W-1:0]        pc_o,
  output logic                         mem_req_o,
  output logic                         mem_we_o,
  output logic [23:0]                  mem_addr_o,
  output logic [7:0]                   mem_wdata_o,
  output logic [`BOME_CCR_W-1:0]       ccr_o,
  output logic                         busy_o,
  output logic                         illegal_o
);
  //////////////////////////////////////////////////////////////////////////////
  // Instruction word used by this unit (16 bits):
  //   [15:12] first op field, [11:8] second op field,
  //   [7]     1 = memory operand addressed by register [6:4], 0 = register byte,
  //   [6:4]   operand register, [3] 1 = bit number from register, 0 = immediate,
  //   [2:0]   immediate bit number, or bit-number register.
  //   Register byte operand takes the low byte of the register at [6:4].
  // First op field 4'h7 is a bit operation, second op field selects which.
  // First op field 4'h7 with second op field BOME_MOVE_WORD and [0]
  // chooses byte (0) or word (1) count block move.
  //////////////////////////////////////////////////////////////////////////////

  initial begin
    if (NREG != 8) begin
      $error("bome_exec: exactly eight general registers are supported");
    end
  end

  logic [31:0]            gr_r [NREG];
  logic [`BOME_PC_W-1:0]  pc_r;
  logic [`BOME_CCR_W-1:0] ccr_r;
  bome_state_e            st_r;
  logic [15:0]            ir_r;
  logic                   word_cnt_r;
  logic [7:0]             byte_r;

  function automatic bome_op_e decode(input logic [15:0] w);
    logic [3:0] op1;
    logic [3:0] op2;
    op1 = w[`BOME_OP1_HI:`BOME_OP1_LO];
    op2 = w[`BOME_OP2_HI:`BOME_OP2_LO];
    decode = BOME_OP_NOP;
    if (op1 == 4'h7) begin
      case (op2)
        4'h0:    decode = BOME_OP_SET;
        4'h1:    decode = BOME_OP_CLEAR;
        4'h2:    decode = BOME_OP_INVERT;
        4'h3:    decode = BOME_OP_TEST;
        4'h4:    decode = BOME_OP_MOVE;
        4'h6:    decode = BOME_OP_CAND;
        4'h7:    decode = w[3] ? BOME_OP_BIT_SET_OP_X : BOME_OP_CANDN;
        4'h8:    decode = BOME_OP_COR;
        4'h9:    decode = w[3] ? BOME_OP_BIT_SET_OP_X : BOME_OP_CORN;
        default: decode = BOME_OP_BIT_SET_OP_X;
      endcase
    end
    else if (op1 != 4'h0) begin
      decode = BOME_OP_BIT_SET_OP_X;
    end
  endfunction : decode

  function automatic logic [2:0] bit_no(input logic [15:0] w, input logic [7:0] rlow);
    bit_no = w[3] ? rlow[2:0] : w[2:0];
  endfunction : bit_no

  function automatic logic [7:0] apply_bit(input bome_op_e op, input logic [7:0] d,
                                           input logic [2:0] n);
    apply_bit = d;
    case (op)
      BOME_OP_SET:    apply_bit[n] = 1'b1;
      BOME_OP_CLEAR:  apply_bit[n] = 1'b0;
      BOME_OP_INVERT: apply_bit[n] = ~d[n];
      default:        apply_bit = d;
    endcase
  endfunction : apply_bit

  function automatic logic [7:0] apply_ccr(input bome_op_e op, input logic [7:0] c,
                                           input logic b);
    apply_ccr = c;
    case (op)
      BOME_OP_TEST:  apply_ccr[`BOME_CCR_Z] = ~b;
      BOME_OP_CAND:  apply_ccr[`BOME_CCR_C] = c[`BOME_CCR_C] & b;
      BOME_OP_CANDN: apply_ccr[`BOME_CCR_C] = c[`BOME_CCR_C] & ~b;
      BOME_OP_COR:   apply_ccr[`BOME_CCR_C] = c[`BOME_CCR_C] | b;
      BOME_OP_CORN:  apply_ccr[`BOME_CCR_C] = c[`BOME_CCR_C] | ~b;
      default:       apply_ccr = c;
    endcase
  endfunction : apply_ccr

  function automatic logic writes_back(input bome_op_e op);
    writes_back = (op == BOME_OP_SET) || (op == BOME_OP_CLEAR) || (op == BOME_OP_INVERT);
  endfunction : writes_back

  //////////////////////////////////////////////////////////////////////////////
  // Combinational view of the current instruction.

  bome_op_e   cur_op;
  bome_op_e   new_op;
  logic [2:0] cur_bit;
  logic [7:0] reg_byte;
  logic [15:0] cnt_now;
  logic       cnt_zero;
  logic [15:0] cnt_dec;
  logic [7:0] opnd;

  always_comb begin
    cur_op   = decode(ir_r);
    new_op   = decode(fetch_word_i);
    reg_byte = gr_r[ir_r[6:4]][7:0];
    cur_bit  = bit_no(ir_r, gr_r[ir_r[2:0]][7:0]);
    cnt_now  = word_cnt_r ? gr_r[`BOME_CNT_IDX][15:0]
                          : {8'h00, gr_r[`BOME_CNT_IDX][7:0]};
    cnt_zero = (cnt_now == 16'h0000);
    cnt_dec  = cnt_now - 16'h0001;
    opnd     = ir_r[7] ? mem_rdata_i : reg_byte;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_r       <= BOME_ST_FETCH;
      ir_r       <= 16'h0000;
      word_cnt_r <= 1'b0;
      byte_r     <= 8'h00;
    end
    else begin
      case (st_r)
        BOME_ST_FETCH: begin
          if (fetch_valid_i) begin
            ir_r       <= fetch_word_i;
            word_cnt_r <= fetch_word_i[0];
            if (new_op == BOME_OP_MOVE) begin
              st_r <= BOME_ST_MVREAD;
            end
            else if (new_op != BOME_OP_NOP && new_op != BOME_OP_BIT_SET_OP_X) begin
              st_r <= BOME_ST_OPREAD;
            end
          end
        end
        BOME_ST_OPREAD: begin
          st_r <= ir_r[7] ? BOME_ST_OPWAIT : BOME_ST_FETCH;
        end
        BOME_ST_OPWAIT: begin
          if (mem_ack_i) begin
            st_r <= writes_back(cur_op) ? BOME_ST_OPWRITE : BOME_ST_FETCH;
          end
        end
        // The write-back must land before the next word, or it could read stale memory.
        BOME_ST_OPWRITE: begin
          if (mem_ack_i) begin
            st_r <= BOME_ST_FETCH;
          end
        end
        BOME_ST_MVREAD: begin
          st_r <= cnt_zero ? BOME_ST_FETCH : BOME_ST_MVWAIT;
        end
        BOME_ST_MVWAIT: begin
          if (mem_ack_i) begin
            byte_r <= mem_rdata_i;
            st_r   <= BOME_ST_MVWRITE;
          end
        end
        BOME_ST_MVWRITE: begin
          if (mem_ack_i) begin
            st_r <= BOME_ST_MVREAD;
          end
        end
        default: st_r <= BOME_ST_FETCH;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // General registers, program counter and condition codes.

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NREG; i++) begin
        gr_r[i] <= 32'h00000000;
      end
    end
    else if (st_r == BOME_ST_OPREAD && !ir_r[7] && writes_back(cur_op)) begin
      gr_r[ir_r[6:4]][7:0] <= apply_bit(cur_op, reg_byte, cur_bit);
    end
    else if (st_r == BOME_ST_MVWRITE && mem_ack_i) begin
      gr_r[`BOME_SRC_IDX] <= gr_r[`BOME_SRC_IDX] + 32'h00000001;
      gr_r[`BOME_DST_IDX] <= gr_r[`BOME_DST_IDX] + 32'h00000001;
      if (word_cnt_r) begin
        gr_r[`BOME_CNT_IDX][15:0] <= cnt_dec;
      end
      else begin
        gr_r[`BOME_CNT_IDX][7:0] <= cnt_dec[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pc_r <= `BOME_PC_RST;
    end
    else if (st_r == BOME_ST_FETCH && fetch_valid_i) begin
      pc_r <= pc_r + `BOME_PC_W'(2);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ccr_r <= `BOME_CCR_RST;
    end
    else if ((st_r == BOME_ST_OPREAD && !ir_r[7]) || (st_r == BOME_ST_OPWAIT && mem_ack_i)) begin
      ccr_r <= apply_ccr(cur_op, ccr_r, opnd[cur_bit]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Memory port. A memory bit operation reads; set, clear and invert then write once the read is acknowledged, waiting again in OPWRITE.

  logic [7:0] wr_byte;
  always_comb begin
    wr_byte = apply_bit(cur_op, mem_rdata_i, cur_bit);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= 24'h000000;
      mem_wdata_o <= 8'h00;
    end
    else begin
      mem_req_o <= 1'b0;
      mem_we_o  <= 1'b0;
      if (st_r == BOME_ST_OPREAD && ir_r[7]) begin
        mem_req_o  <= 1'b1;
        mem_addr_o <= gr_r[ir_r[6:4]][23:0];
      end
      else if (st_r == BOME_ST_OPWAIT && mem_ack_i && writes_back(cur_op)) begin
        mem_req_o   <= 1'b1;
        mem_we_o    <= 1'b1;
        mem_wdata_o <= wr_byte;
      end
      else if (st_r == BOME_ST_MVREAD && !cnt_zero) begin
        mem_req_o  <= 1'b1;
        mem_addr_o <= gr_r[`BOME_SRC_IDX][23:0];
      end
      else if (st_r == BOME_ST_MVWAIT && mem_ack_i) begin
        mem_req_o   <= 1'b1;
        mem_we_o    <= 1'b1;
        mem_addr_o  <= gr_r[`BOME_DST_IDX][23:0];
        mem_wdata_o <= mem_rdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      fetch_req_o <= 1'b0;
      busy_o      <= 1'b0;
      illegal_o   <= 1'b0;
      pc_o        <= `BOME_PC_RST;
      ccr_o       <= `BOME_CCR_RST;
    end
    else begin
      fetch_req_o <= (st_r == BOME_ST_FETCH) && !fetch_valid_i;
      busy_o      <= (st_r != BOME_ST_FETCH);
      illegal_o   <= (st_r == BOME_ST_FETCH) && fetch_valid_i && (new_op == BOME_OP_BIT_SET_OP_X);
      pc_o        <= pc_r;
      ccr_o       <= ccr_r;
    end
  end
endmodule : bome_exec
`default_nettype wire

// ### verif/bome_exec_asserts.sv
// Port assertions for the bit-operation and block-move execution unit.
`timescale 1ns/10ps
`default_nettype none
module bome_exec_asserts #(
  parameter int NREG = 8
) (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic [15:0] fetch_word_i,
  input wire logic        fetch_valid_i,
  input wire logic [7:0]  mem_rdata_i,
  input wire logic        mem_ack_i,
  input wire logic        fetch_req_o,
  input wire logic [23:0] pc_o,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic [7:0]  ccr_o,
  input wire logic        busy_o,
  input wire logic        illegal_o
);
  logic [7:0] rd_r;
  always_ff @(posedge ref_clk_i) begin
    if (mem_ack_i) begin
      rd_r <= mem_rdata_i;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_reset_values: assert property (@(posedge ref_clk_i) disable iff (1'b0)
    !rst_n_i |=> ccr_o == 8'h80 && pc_o == 24'h000000) else $error("reset values wrong");
  a_req_one_cycle: assert property (mem_req_o |=> !mem_req_o)
    else $error("request longer than a cycle");
  a_fetch_not_busy: assert property (busy_o |-> !fetch_req_o)
    else $error("fetch offered while busy");
  a_req_in_busy: assert property (mem_req_o |-> busy_o)
    else $error("access outside an instruction");
  a_write_after_ack: assert property (mem_req_o && mem_we_o |->
    $past(mem_ack_i) || $past(mem_ack_i, 2)) else $error("write without read");
  a_write_one_bit: assert property (mem_req_o && mem_we_o |->
    $countones(mem_wdata_o ^ rd_r) <= 1) else $error("write changes several bits");
  a_pc_step_two: assert property ($changed(pc_o) |-> pc_o == $past(pc_o) + 24'h2)
    else $error("program counter step wrong");
  a_fetch_taken: assert property (fetch_req_o && fetch_valid_i |-> ##[1:2] !fetch_req_o)
    else $error("word not taken");
  a_illegal_pulse: assert property (illegal_o |=> !illegal_o)
    else $error("illegal flag too long");
  a_addr_hold: assert property (!mem_req_o |-> $stable(mem_addr_o) && $stable(mem_wdata_o))
    else $error("address moved between requests");
endmodule : bome_exec_asserts
bind bome_exec bome_exec_asserts #(.NREG(NREG)) bome_exec_asserts_i (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .fetch_word_i(fetch_word_i),
  .fetch_valid_i(fetch_valid_i), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i),
  .fetch_req_o(fetch_req_o), .pc_o(pc_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
  .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .ccr_o(ccr_o), .busy_o(busy_o),
  .illegal_o(illegal_o));
`default_nettype wire

// ### verif/bome_exec_tb.sv
// Self-checking testbench of the bit-operation and block-move execution unit.
`timescale 1ns/10ps
`default_nettype none
module bome_exec_tb
  import bome_pkg::*;
;
  localparam logic [15:0] CORNER [10] = '{16'h7054, 16'h7067, 16'h7040, 16'h7041, 16'h70d3,
                                          16'h7400, 16'h7400, 16'h7040, 16'h7401, 16'h7708};
  localparam logic [3:0]  OPS [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9};
  logic        ref_clk_i     = 1'b0;
  logic        rst_n_i       = 1'b0;
  logic        fetch_valid_i = 1'b0;
  logic        mem_ack_i     = 1'b0;
  logic [15:0] fetch_word_i  = 16'h0000;
  logic [7:0]  mem_rdata_i   = 8'h00;
  logic        fetch_req_o, mem_req_o, mem_we_o, busy_o, illegal_o, pend, ill_seen, eill;
  logic [23:0] pc_o, mem_addr_o, epc;
  logic [7:0]  mem_wdata_o, ccr_o, eccr;
  logic [7:0]  dmem [256];
  logic [7:0]  emem [256];
  logic [31:0] r [8];
  logic [15:0] w;
  logic        pwe;
  logic [7:0]  paddr, pdata;
  int          miscompares, compares, cycles, dly;
  bome_exec bome_exec_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .fetch_word_i(fetch_word_i),
    .fetch_valid_i(fetch_valid_i), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i),
    .fetch_req_o(fetch_req_o), .pc_o(pc_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .ccr_o(ccr_o), .busy_o(busy_o),
    .illegal_o(illegal_o));
  always #20 ref_clk_i = ~ref_clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  // Byte memory answering after zero to two idle cycles; data scrambles between answers.
  always @(posedge ref_clk_i) begin
    if (mem_req_o === 1'b1) begin
      pend = 1'b1;
      dly = $urandom % 3;
      pwe = mem_we_o;
      paddr = mem_addr_o[7:0];
      pdata = mem_wdata_o;
    end
    if (pend && dly == 0 && mem_req_o !== 1'b1) begin
      pend = 1'b0;
      mem_ack_i <= 1'b1;
      if (pwe === 1'b1) dmem[paddr] = pdata;
      else mem_rdata_i <= dmem[paddr];
    end else begin
      mem_ack_i <= 1'b0;
      mem_rdata_i <= ~mem_rdata_i;
      if (dly > 0 && mem_req_o !== 1'b1) dly--;
    end
  end
  always @(posedge ref_clk_i) begin
    if (illegal_o === 1'b1) ill_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      miscompares++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] bit_calc(input logic [3:0] op, input logic [7:0] v,
                                           input logic [2:0] n, input logic [7:0] c);
    case (op)
      4'h0: v[n] = 1'b1;
      4'h1: v[n] = 1'b0;
      4'h2: v[n] = ~v[n];
      4'h3: c[2] = ~v[n];
      4'h6: c[0] = c[0] & v[n];
      4'h7: c[0] = c[0] & ~v[n];
      4'h8: c[0] = c[0] | v[n];
      default: c[0] = c[0] | ~v[n];
    endcase
    return {v, c};
  endfunction : bit_calc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic model(input logic [15:0] iw);
    logic [2:0] n;
    logic [7:0] v;
    int         cnt;
    n = iw[3] ? r[iw[2:0]][2:0] : iw[2:0];
    epc = epc + 24'h2;
    eill = (iw[11:8] == 4'h7 || iw[11:8] == 4'h9) && iw[3];
    if (iw[11:8] == 4'h4) begin
      cnt = iw[0] ? int'(r[4][15:0]) : int'(r[4][7:0]);
      for (int i = 0; i < cnt; i++) begin
        emem[r[6][7:0]] = emem[r[5][7:0]];
        r[5]++;
        r[6]++;
      end
      if (iw[0]) r[4][15:0] = 16'h0000;
      else r[4][7:0] = 8'h00;
    end else if (!eill) begin
      v = iw[7] ? emem[r[iw[6:4]][7:0]] : r[iw[6:4]][7:0];
      {v, eccr} = bit_calc(iw[11:8], v, n, eccr);
      if (iw[7]) emem[r[iw[6:4]][7:0]] = v;
      else r[iw[6:4]][7:0] = v;
    end
  endtask : model
  task automatic run(input logic [15:0] iw);
    int n;
    for (n = 0; n < 4000 && fetch_req_o !== 1'b1; n++) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
    fetch_word_i <= iw;
    fetch_valid_i <= 1'b1;
    ill_seen = 1'b0;
    @(posedge ref_clk_i);
    fetch_valid_i <= 1'b0;
    repeat (2) @(negedge ref_clk_i);
    for (n = 0; n < 4000 && fetch_req_o !== 1'b1; n++) @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    model(iw);
    chk(ccr_o, eccr);
    chk(pc_o, epc);
    chk(ill_seen, eill);
    n = 0;
    for (int i = 0; i < 256; i++) if (dmem[i] !== emem[i]) n++;
    chk(n, 0);
  endtask : run
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(99560));
    pend = 1'b0;
    dly = 0;
    ill_seen = 1'b0;
    eccr = 8'h80;
    epc = 24'h000000;
    for (int i = 0; i < 8; i++) r[i] = 32'h00000000;
    for (int i = 0; i < 256; i++) begin
      dmem[i] = 8'($urandom);
      emem[i] = dmem[i];
    end
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(negedge ref_clk_i);
    chk(ccr_o, 8'h80);
    chk(pc_o, 24'h000000);
    foreach (CORNER[i]) run(CORNER[i]);
    repeat (150) begin
      w = {4'h7, OPS[$urandom % 9], 8'($urandom)};
      if (w[11:8] == 4'h4) w[7:1] = 7'h00;
      run(w);
    end
    end_of_test();
  end
endmodule : bome_exec_tb
`default_nettype wire
